// *** spu_regs.svh ***
`ifndef SPU_REGS_SVH
`define SPU_REGS_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define SPU_IDX_CTRL     8'h98
`define SPU_IDX_DATA     8'h99
`define SPU_IDX_CFG      8'h9A
`define SPU_ADDR_CTRL    ({2'h0, `SPU_IDX_CTRL, 2'h0})
`define SPU_ADDR_DATA    ({2'h0, `SPU_IDX_DATA, 2'h0})
`define SPU_ADDR_CFG     ({2'h0, `SPU_IDX_CFG, 2'h0})

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SPU_B_MODE_HI    7
`define SPU_B_MODE_LO    6
`define SPU_B_VARIANT    5
`define SPU_B_REN        4
`define SPU_B_TX9        3
`define SPU_B_RX9        2
`define SPU_B_TXDONE     1
`define SPU_B_RXDONE     0
`define SPU_B_DOUBLER    0
`define SPU_B_TMR2       1
`define SPU_CTRL_RST     5'h00
`define SPU_DATA_RST     8'h00
`define SPU_CFG_RST      2'h0

// ----------------------------------------------------------------
// Modes and timing counts
// ----------------------------------------------------------------
`define SPU_MODE0        2'h0
`define SPU_MODE1        2'h1
`define SPU_MODE2        2'h2
`define SPU_OVS_LAST     4'hF
`define SPU_MID          4'h7
`define SPU_M2_DIV_SLOW  4'h3
`define SPU_M2_DIV_FAST  4'h1
`define SPU_M0_HALF_SLOW 4'h5
`define SPU_M0_HALF_FAST 4'h1
`define SPU_M0_BITS      4'h8
`define SPU_BITS10       4'hA
`define SPU_BITS11       4'hB
`define SPU_RX_LAST      4'h9

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define SPU_RESP_OKAY    2'h0
`define SPU_RESP_SLVERR  2'h2

`endif

// *** spu_pkg.sv ***
package spu_pkg;
  // Transmit / mode-0 shift engine
  typedef enum logic {TX_IDLE, TX_RUN} spu_tx_st_t;
  // Asynchronous receiver
  typedef enum logic {RX_IDLE, RX_BITS} spu_rx_st_t;
endpackage : spu_pkg

// *** spu_baud.sv ***
`timescale 1ns/100ps
`include "spu_regs.svh"
module spu_baud
  import spu_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       pclk_en,
  input  wire logic [1:0] mode,
  input  wire logic       variant,
  input  wire logic       doubler,
  input  wire logic       tmr2_sel,
  input  wire logic       t1_ovf,
  input  wire logic       t2_ovf,
  input  wire logic       restart,
  output logic            tick16,
  output logic            half0
);

  logic [3:0] cnt_q;    // Shared pclk divider
  logic [3:0] limit;    // Divider terminal count
  logic       t1_odd_q; // Halves timer 1 rate when not doubled
  logic       div_hit;  // Terminal count reached

  // ----------------------------------------------------------------
  // Divider limit per mode
  // ----------------------------------------------------------------
  always_comb begin
    if (mode == `SPU_MODE0) begin
      limit = variant ? `SPU_M0_HALF_FAST : `SPU_M0_HALF_SLOW;
    end else begin
      limit = doubler ? `SPU_M2_DIV_FAST : `SPU_M2_DIV_SLOW;
    end
  end

  // Idle stops the peripheral clock, so nothing advances
  assign div_hit = pclk_en && (cnt_q == limit);

  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      cnt_q <= '0;
    end else if (pclk_en) begin
      cnt_q <= div_hit ? '0 : cnt_q + 4'h1;
    end
  end

  // Timer 1 overflow halving
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t1_odd_q <= 1'b0;
    end else if (t1_ovf && pclk_en) begin
      t1_odd_q <= !t1_odd_q;
    end
  end

  // ----------------------------------------------------------------
  // Tick selection
  // ----------------------------------------------------------------
  always_comb begin
    half0  = (mode == `SPU_MODE0) && div_hit;
    tick16 = 1'b0;
    if (mode == `SPU_MODE2) begin
      tick16 = div_hit;
    end else if (mode != `SPU_MODE0) begin
      // Timer rate source for modes 1 and 3
      if (tmr2_sel) begin
        tick16 = t2_ovf && pclk_en;
      end else begin
        tick16 = t1_ovf && pclk_en && (doubler || t1_odd_q);
      end
    end
  end

  // Mode 2 without doubler: one sample tick per 4 pclk, so 64 per bit
  sequence s_quiet3;
    (pclk_en && mode == `SPU_MODE2 && !doubler && !restart)[*3];
  endsequence
  property p_m2_rate;
    @(posedge aclk) disable iff (!aresetn)
      (tick16 && mode == `SPU_MODE2 && !doubler) ##1 s_quiet3
      ##1 (pclk_en && mode == `SPU_MODE2 && !doubler) |-> tick16;
  endproperty
  a_m2_rate: assert property (p_m2_rate)
    else $error("mode 2 sample tick spacing wrong");

  property p_idle_freeze;
    @(posedge aclk) disable iff (!aresetn)
      !pclk_en |-> !tick16 && !half0;
  endproperty
  a_idle_freeze: assert property (p_idle_freeze)
    else $error("tick while peripheral clock halted");

endmodule : spu_baud

// *** spu_top.sv ***
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`include "spu_regs.svh"
module spu_top
  import spu_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        idle_mode,
  input  wire logic        timer1_ovf,
  input  wire logic        timer2_ovf,
  output logic             serial_tx_pin,
  input  wire logic        serial_rx_pin_sense,
  output logic             serial_rx_pin_drive,
  output logic             serial_rx_pin_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [11:0] awaddr_q;      // Held write address
  logic [7:0]  wdata_q;       // Held write data, low lane
  logic        wstrb0_q;      // Held low-lane strobe
  logic [4:0]  ctrl_q;        // Mode, variant, enable, tx ninth
  logic [1:0]  cfg_q;         // Doubler and timer select
  logic        rx9_q;         // Received ninth bit
  logic        tx_done_q;     // Sticky transmit flag
  logic        rx_done_q;     // Sticky receive flag
  logic [7:0]  rx_buf_q;      // Receive buffer
  logic        wr_do;         // Both write halves held
  logic        ctrl_wr;       // Control register write
  logic        data_wr;       // Data buffer write
  logic        cfg_wr;        // Config register write
  logic [1:0]  mode;          // Current mode
  logic        variant;       // Third mode bit
  logic        pclk_en;       // Peripheral clock running
  logic        tick16;        // 16x sample tick
  logic        half0;         // Mode 0 half period
  spu_tx_st_t  tx_st_q;       // Shift engine state
  logic [10:0] tx_sh_q;       // Shift register
  logic [3:0]  tx_cnt_q;      // Bits remaining
  logic [3:0]  tx_ph_q;       // Tick phase in bit
  logic        tx_m0_q;       // Engine running mode 0
  logic        m0_rx_q;       // Mode 0 transfer is receive
  logic        m0_rx_go;      // Mode 0 reception request
  logic        tx_set;        // Transmit done event
  logic        m0_load;       // Mode 0 byte received
  logic        rx_m_q;        // Synchroniser first stage
  logic        rx_s_q;        // Synchronised rx line
  logic        rx_p_q;        // Previous rx line
  spu_rx_st_t  rx_st_q;       // Receiver state
  logic [3:0]  rx_ph_q;       // Tick phase in bit
  logic [3:0]  rx_cnt_q;      // Bit index
  logic [7:0]  rx_sh_q;       // Receive shift
  logic        rx_mid;        // Mid-bit sample moment
  logic        rx_fin;        // Last async sample
  logic        rx_take;       // Async byte accepted

  assign mode    = ctrl_q[4:3];
  assign variant = ctrl_q[2];
  assign pclk_en = !idle_mode;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data taken in either order; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SPU_RESP_OKAY;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb0_q      <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata[7:0];
        wstrb0_q     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        // Unmapped address answers with an error
        s_axi_bresp  <= (ctrl_wr || data_wr || cfg_wr ||
                         awaddr_q == `SPU_ADDR_CTRL ||
                         awaddr_q == `SPU_ADDR_DATA ||
                         awaddr_q == `SPU_ADDR_CFG) ?
                        `SPU_RESP_OKAY : `SPU_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign wr_do   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign ctrl_wr = wr_do && wstrb0_q && (awaddr_q == `SPU_ADDR_CTRL);
  assign data_wr = wr_do && wstrb0_q && (awaddr_q == `SPU_ADDR_DATA);
  assign cfg_wr  = wr_do && wstrb0_q && (awaddr_q == `SPU_ADDR_CFG);

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Data address reads the receive side only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `SPU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `SPU_RESP_OKAY;
      if (s_axi_araddr == `SPU_ADDR_CTRL) begin
        s_axi_rdata <= {24'h0, ctrl_q, rx9_q, tx_done_q, rx_done_q};
      end else if (s_axi_araddr == `SPU_ADDR_DATA) begin
        s_axi_rdata <= {24'h0, rx_buf_q};
      end else if (s_axi_araddr == `SPU_ADDR_CFG) begin
        s_axi_rdata <= {30'h0, cfg_q};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= `SPU_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Control fields written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `SPU_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= wdata_q[`SPU_B_MODE_HI:`SPU_B_TX9];
    end
  end

  // Doubler and timer choice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= `SPU_CFG_RST;
    end else if (cfg_wr) begin
      cfg_q <= {wdata_q[`SPU_B_TMR2], wdata_q[`SPU_B_DOUBLER]};
    end
  end

  // Done flags: a hardware set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_done_q <= 1'b0;
      rx_done_q <= 1'b0;
    end else begin
      tx_done_q <= tx_set || (ctrl_wr ? wdata_q[`SPU_B_TXDONE] : tx_done_q);
      rx_done_q <= m0_load || rx_take ||
                   (ctrl_wr ? wdata_q[`SPU_B_RXDONE] : rx_done_q);
    end
  end

  // Receive buffer and ninth bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_q <= `SPU_DATA_RST;
      rx9_q    <= 1'b0;
    end else if (m0_load) begin
      rx_buf_q <= {rx_s_q, tx_sh_q[7:1]};
    end else if (rx_take) begin
      rx_buf_q <= rx_sh_q;
      rx9_q    <= rx_s_q;
    end
  end

  // ----------------------------------------------------------------
  // Rate generation
  // ----------------------------------------------------------------
  spu_baud u_baud (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pclk_en  (pclk_en),
    .mode     (mode),
    .variant  (variant),
    .doubler  (cfg_q[`SPU_B_DOUBLER]),
    .tmr2_sel (cfg_q[`SPU_B_TMR2]),
    .t1_ovf   (timer1_ovf),
    .t2_ovf   (timer2_ovf),
    .restart  ((tx_st_q == TX_IDLE) && (mode == `SPU_MODE0)),
    .tick16   (tick16),
    .half0    (half0)
  );

  // ----------------------------------------------------------------
  // Shift engine: async transmit and all of mode 0
  // ----------------------------------------------------------------
  // Mode 0 reception starts while enabled and flag clear
  assign m0_rx_go = (mode == `SPU_MODE0) && ctrl_q[1] && !rx_done_q &&
                    pclk_en && !data_wr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q             <= TX_IDLE;
      tx_sh_q             <= '0;
      tx_cnt_q            <= '0;
      tx_ph_q             <= '0;
      tx_m0_q             <= 1'b0;
      m0_rx_q             <= 1'b0;
      serial_tx_pin       <= 1'b1;
      serial_rx_pin_drive <= 1'b1;
      serial_rx_pin_oe    <= 1'b0;
    end else begin
      unique case (tx_st_q)
        TX_IDLE: begin
          tx_ph_q <= '0;
          if (data_wr) begin
            // Writing the buffer starts a send
            tx_st_q <= TX_RUN;
            m0_rx_q <= 1'b0;
            tx_m0_q <= (mode == `SPU_MODE0);
            serial_tx_pin <= 1'b0;
            if (mode == `SPU_MODE0) begin
              tx_sh_q             <= {3'h7, wdata_q};
              tx_cnt_q            <= `SPU_M0_BITS;
              serial_rx_pin_drive <= wdata_q[0];
              serial_rx_pin_oe    <= 1'b1;
            end else begin
              // Stop, ninth or stop, data, start bit
              tx_sh_q  <= {1'b1, mode[1] ? ctrl_q[0] : 1'b1,
                           wdata_q, 1'b0};
              tx_cnt_q <= mode[1] ? `SPU_BITS11 : `SPU_BITS10;
            end
          end else if (m0_rx_go) begin
            tx_st_q       <= TX_RUN;
            m0_rx_q       <= 1'b1;
            tx_m0_q       <= 1'b1;
            tx_cnt_q      <= `SPU_M0_BITS;
            serial_tx_pin <= 1'b0;
          end
        end
        TX_RUN: begin
          if (tx_m0_q) begin
            // Tx pin is the shift clock; peer samples on its rise
            if (half0 && !serial_tx_pin) begin
              serial_tx_pin <= 1'b1;
            end else if (half0) begin
              tx_cnt_q <= tx_cnt_q - 4'h1;
              if (m0_rx_q) begin
                tx_sh_q[7:0] <= {rx_s_q, tx_sh_q[7:1]};
              end else begin
                tx_sh_q             <= {1'b1, tx_sh_q[10:1]};
                serial_rx_pin_drive <= tx_sh_q[1];
              end
              if (tx_cnt_q == 4'h1) begin
                tx_st_q             <= TX_IDLE;
                serial_rx_pin_oe    <= 1'b0;
                serial_rx_pin_drive <= 1'b1;
              end else begin
                serial_tx_pin <= 1'b0;
              end
            end
          end else if (tick16) begin
            // Each async bit lasts 16 sample ticks
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == `SPU_OVS_LAST) begin
              tx_cnt_q <= tx_cnt_q - 4'h1;
              if (tx_cnt_q == 4'h1) begin
                tx_st_q       <= TX_IDLE;
                serial_tx_pin <= 1'b1;
              end else begin
                tx_sh_q       <= {1'b1, tx_sh_q[10:1]};
                serial_tx_pin <= tx_sh_q[1];
              end
            end
          end
        end
      endcase
    end
  end

  // Done events at the end of the last data bit, or of the ninth bit in modes 2 and 3
  assign tx_set  = (tx_st_q == TX_RUN) && (tx_m0_q ?
                   (half0 && serial_tx_pin && tx_cnt_q == 4'h1 && !m0_rx_q) :
                   (tick16 && tx_ph_q == `SPU_OVS_LAST &&
                    tx_cnt_q == 4'h2));
  assign m0_load = (tx_st_q == TX_RUN) && tx_m0_q && m0_rx_q && half0 &&
                   serial_tx_pin && tx_cnt_q == 4'h1;

  // ----------------------------------------------------------------
  // Rx pin synchroniser
  // ----------------------------------------------------------------
  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
      rx_p_q <= 1'b1;
    end else begin
      rx_m_q <= serial_rx_pin_sense;
      rx_s_q <= rx_m_q;
      rx_p_q <= rx_s_q;
    end
  end

  // ----------------------------------------------------------------
  // Asynchronous receiver
  // ----------------------------------------------------------------
  assign rx_mid  = (rx_st_q == RX_BITS) && tick16 && (rx_ph_q == `SPU_MID);
  assign rx_fin  = rx_mid && (rx_cnt_q == `SPU_RX_LAST);
  // Multiprocessor variant keeps only frames with the bit after the data set (ninth bit, or stop bit in mode 1)
  assign rx_take = rx_fin && !rx_done_q && (!variant || rx_s_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q  <= RX_IDLE;
      rx_ph_q  <= '0;
      rx_cnt_q <= '0;
      rx_sh_q  <= '0;
    end else begin
      unique case (rx_st_q)
        RX_IDLE: begin
          rx_ph_q  <= '0;
          rx_cnt_q <= '0;
          // Falling edge starts a frame when enabled
          if (mode != `SPU_MODE0 && ctrl_q[1] && pclk_en &&
              rx_p_q && !rx_s_q) begin
            rx_st_q <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (tick16) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == `SPU_OVS_LAST) begin
              rx_cnt_q <= rx_cnt_q + 4'h1;
            end
          end
          if (rx_mid) begin
            if (rx_cnt_q == '0) begin
              // A glitch that is high at mid-bit is no start
              if (rx_s_q) begin
                rx_st_q <= RX_IDLE;
              end
            end else if (rx_fin) begin
              rx_st_q <= RX_IDLE;
            end else begin
              rx_sh_q <= {rx_s_q, rx_sh_q[7:1]};
            end
          end
          if (mode == `SPU_MODE0 || !ctrl_q[1]) begin
            rx_st_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_async_load;
    tx_st_q == TX_IDLE && data_wr && mode != `SPU_MODE0;
  endsequence

  property p_start_bit;
    @(posedge aclk) disable iff (!aresetn)
      s_async_load |=> !serial_tx_pin && tx_st_q == TX_RUN;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("frame did not open with start bit");

  property p_ninth;
    @(posedge aclk) disable iff (!aresetn)
      (s_async_load and mode[1]) |=>
        tx_sh_q[9] == $past(ctrl_q[0]) && tx_cnt_q == `SPU_BITS11;
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("ninth bit not taken from control field");

  property p_tx_sticky;
    @(posedge aclk) disable iff (!aresetn)
      tx_done_q && !ctrl_wr |=> tx_done_q;
  endproperty
  a_tx_sticky: assert property (p_tx_sticky)
    else $error("transmit flag dropped by hardware");

  property p_rx_sticky;
    @(posedge aclk) disable iff (!aresetn)
      rx_done_q && !ctrl_wr |=> rx_done_q;
  endproperty
  a_rx_sticky: assert property (p_rx_sticky)
    else $error("receive flag dropped by hardware");

  property p_ren_gate;
    @(posedge aclk) disable iff (!aresetn)
      !ctrl_q[1] && rx_st_q == RX_IDLE |=> rx_st_q == RX_IDLE;
  endproperty
  a_ren_gate: assert property (p_ren_gate)
    else $error("receiver started while disabled");

  property p_mp_addr;
    @(posedge aclk) disable iff (!aresetn)
      $rose(rx_done_q) && variant && mode != `SPU_MODE0 &&
      !$past(m0_load) && !$past(ctrl_wr) |-> rx9_q;
  endproperty
  a_mp_addr: assert property (p_mp_addr)
    else $error("data frame flagged in multiprocessor variant");

  property p_m0_clk;
    @(posedge aclk) disable iff (!aresetn)
      tx_st_q == TX_RUN && tx_m0_q && !half0 |=> $stable(serial_tx_pin);
  endproperty
  a_m0_clk: assert property (p_m0_clk)
    else $error("shift clock moved off its half period");

endmodule : spu_top

// *** spu_peer.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Remote async peer, line idles at mark
// ----------------------------------------
module spu_peer (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [8:0] dat,
  output logic            line,
  output logic            busy
);
  localparam int PER = 64; // Mode 2 bit, no doubler
  logic [10:0] sh_q;       // Frame bits, LSB first
  int          n_q = 0;    // Bits left
  int          c_q = 0;    // Cycles in bit
  initial line = 1'b1;
  assign busy = (n_q != 0);
  // Start, eight data, ninth, stop
  always @(posedge aclk) begin
    if (n_q == 0) begin
      line <= 1'b1;
      if (go) begin
        sh_q <= {1'b1, dat, 1'b0};
        n_q  <= 11;
      end
    end else begin
      line <= sh_q[0];
      c_q  <= (c_q == PER - 1) ? 0 : c_q + 1;
      if (c_q == PER - 1) begin
        sh_q <= sh_q >> 1;
        n_q  <= n_q - 1;
      end
    end
  end
endmodule : spu_peer

// ----------------------------------------
// Mode 0 far side: shift register on clock rise
// ----------------------------------------
module spu_shift_peer (
  input  wire logic        sclk,
  input  wire logic        sdat,
  input  wire logic        sen,
  output logic [7:0]       sh,
  output logic [31:0]      per
);
  time t_q = 0; // Time of the previous rise
  // Data line is steady at the rise, it moves on the fall
  always @(posedge sclk) begin
    if (sen) begin
      sh  <= {sdat, sh[7:1]};
      per <= 32'($time - t_q);
      t_q <= $time;
    end
  end
endmodule : spu_shift_peer

// *** testbench.sv ***
`timescale 1ns/100ps
`include "spu_regs.svh"
module testbench;
  logic aclk = 0, aresetn = 0, go = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic aw = 0, wv = 0, bready = 0, ar = 0, rready = 0;
  logic [8:0] pdat = 0;
  logic [1:0] r;
  logic [10:0] fr;   // Expected frame, LSB first
  logic t2 = 0, idl = 0; // Timer 2 overflow, idle request
  wire [7:0] m0_sh;      // Byte seen by mode 0 peer
  wire [31:0] m0_per;    // Last shift clock period, ns
  logic [45:0] rows [4] = '{
    {`SPU_ADDR_CTRL, 32'h0, 2'h0}, {`SPU_ADDR_DATA, 32'h0, 2'h0},
    {`SPU_ADDR_CFG, 32'h0, 2'h0}, {12'h26C, 32'h0, 2'h2}};
  wire awr, wr_r, bv, arr, rv, tx, drv, oe, pl, pb;
  wire [1:0] br, rr;
  wire [31:0] rdata;
  wire sense = oe ? drv : pl;
  int n_fail = 0, tests_run = 0;
  always #20 aclk = ~aclk;
  spu_top u_spu_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(aw), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(ar),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .idle_mode(idl),
    .timer1_ovf(1'b0), .timer2_ovf(t2), .serial_tx_pin(tx),
    .serial_rx_pin_sense(sense), .serial_rx_pin_drive(drv),
    .serial_rx_pin_oe(oe));
  spu_peer u_spu_peer (.aclk(aclk), .go(go), .dat(pdat), .line(pl),
    .busy(pb));
  spu_shift_peer u_spu_shift_peer (.sclk(tx), .sdat(drv), .sen(oe),
    .sh(m0_sh), .per(m0_per));
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Write: address and data offered together
  task wrt(input logic [11:0] a, input logic [7:0] v);
    awaddr <= a; wdata <= {24'h0, v}; aw <= 1; wv <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awr) aw <= 0;
      if (wr_r) wv <= 0;
    end while (!bv);
    bready <= 0;
    @(posedge aclk);
  endtask : wrt
  // Read one word, hold rready until rvalid
  task rd(input logic [11:0] a, output logic [31:0] v);
    araddr <= a; ar <= 1; rready <= 1;
    do @(posedge aclk); while (!arr);
    ar <= 0;
    do @(posedge aclk); while (!rv);
    v = rdata; r = rr; rready <= 0;
    @(posedge aclk);
  endtask : rd
  // Peer sends one frame, wait until line idle
  task send(input logic [8:0] v);
    pdat <= v; go <= 1;
    @(posedge aclk);
    go <= 0;
    do @(posedge aclk); while (pb);
  endtask : send
  task results;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // Hang guard, about four times the expected run
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    results;
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    foreach (rows[i]) begin
      rd(rows[i][45:34], d);
      chk(d, rows[i][33:2]);
      chk(r, rows[i][1:0]);
    end
    // Mode 2 send normal and doubled, then mode 1 on timer 2
    for (int k = 0; k < 3; k++) begin
      t2 <= (k == 2);
      wrt(`SPU_ADDR_CFG, k[7:0]);
      wrt(`SPU_ADDR_CTRL, k < 2 ? 8'h88 : 8'h48);
      wrt(`SPU_ADDR_DATA, 8'hA5);
      fr = {2'b11, 8'hA5, 1'b0};
      while (tx) @(posedge aclk);
      repeat (32 >> k) @(posedge aclk);
      for (int i = 0; i < 11; i++) begin
        chk(tx, fr[i]);
        repeat (64 >> k) @(posedge aclk);
      end
      rd(`SPU_ADDR_CTRL, d);
      chk(d, k < 2 ? 32'h8A : 32'h4A);
    end
    repeat (200) @(posedge aclk);
    rd(`SPU_ADDR_CTRL, d);
    chk(d, 32'h4A);
    // Mode 0 send, slow then fast shift clock
    for (int k = 0; k < 2; k++) begin
      wrt(`SPU_ADDR_CTRL, k ? 8'h20 : 8'h00);
      wrt(`SPU_ADDR_DATA, k ? 8'hC3 : 8'h5A);
      repeat (110) @(posedge aclk);
      chk(m0_sh, k ? 8'hC3 : 8'h5A);
      chk(m0_per, k ? 160 : 480);
      chk({tx, oe}, 2'b10);
      rd(`SPU_ADDR_CTRL, d);
      chk(d, k ? 32'h22 : 32'h02);
    end
    // Mode 2 receive, plain then multiprocessor
    wrt(`SPU_ADDR_CFG, 8'h00);
    wrt(`SPU_ADDR_CTRL, 8'h90);
    send(9'h13C);
    rd(`SPU_ADDR_DATA, d);
    chk(d, 32'h3C);
    rd(`SPU_ADDR_CTRL, d);
    chk(d, 32'h95);
    wrt(`SPU_ADDR_CTRL, 8'hB0);
    send(9'h0C3);
    rd(`SPU_ADDR_CTRL, d);
    chk(d, 32'hB4);
    // Frame sent while the port idles is never seen
    idl <= 1;
    send(9'h1AA);
    idl <= 0;
    rd(`SPU_ADDR_DATA, d);
    chk(d, 32'h3C);
    send(9'h1C3);
    rd(`SPU_ADDR_DATA, d);
    chk(d, 32'hC3);
    rd(`SPU_ADDR_CTRL, d);
    chk(d, 32'hB5);
    // Reset in mid-frame: line back to mark, control register cleared
    wrt(`SPU_ADDR_DATA, 8'h00);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    chk(tx, 1'b1);
    aresetn <= 1;
    @(posedge aclk);
    rd(`SPU_ADDR_CTRL, d);
    chk(d, 32'h0);
    results;
  end
endmodule : testbench
